// ===== eqfir_conv_model.sv
`timescale 1ns/1ps
`default_nettype none

module eqfir_conv_model (
	// clock
	input wire logic clk,
	// samples toward the equalizer
	output logic a_valid,
	output logic [eqfir_pkg::SAMPLE_W-1:0] a_sample,
	output logic b_valid,
	output logic [eqfir_pkg::SAMPLE_W-1:0] b_sample,
	// samples handed on downstream
	input wire logic oa_valid,
	input wire logic [eqfir_pkg::SAMPLE_W-1:0] oa_sample,
	input wire logic ob_valid,
	input wire logic [eqfir_pkg::SAMPLE_W-1:0] ob_sample
);
	logic [eqfir_pkg::SAMPLE_W-1:0] qa[$];
	logic [eqfir_pkg::SAMPLE_W-1:0] qb[$];

	// idle lanes at time zero
	initial
	begin
		a_valid = 1'b0;
		a_sample = 12'h000;
		b_valid = 1'b0;
		b_sample = 12'h000;
	end

	// one converter cycle; an idle lane shows inverted stale data
	task automatic push(input logic va, input logic [11:0] xa,
		input logic vb, input logic [11:0] xb);
		@(posedge clk);
		a_valid <= va;
		a_sample <= va ? xa : ~a_sample;
		b_valid <= vb;
		b_sample <= vb ? xb : ~b_sample;
	endtask

	// down-conversion side takes every sample handed on
	always @(posedge clk)
	begin
		if (oa_valid === 1'b1)
			qa.push_back(oa_sample);
		if (ob_valid === 1'b1)
			qb.push_back(ob_sample);
	end
endmodule

`default_nettype wire

// ===== eqfir_pkg.sv
package eqfir_pkg;

	// sample and coefficient geometry
	localparam int SAMPLE_W = 12;
	localparam int CENTER_W = 18;
	localparam int SIDE_W = 12;
	localparam int TAPS = 9;
	localparam int CENTER_TAP = 4;
	localparam int FRAC_W = 16;
	localparam int ACC_W = 40;
	localparam int LSB_SEL_W = 3;
	localparam int IDX_W = 4;

	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int COUNT_W = 16;

	// lsb weight select: 0 means 2^-10, 6 means 2^-16
	localparam logic [LSB_SEL_W-1:0] LSB_SEL_MAX = 3'h6;
	localparam logic [LSB_SEL_W-1:0] CENTER_SHIFT = 3'h0;

	// equalizer_mode_sel values
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ON = 2'h2;

	// register offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] BANK_A_OFS = 8'h40;
	localparam logic [ADDR_W-1:0] BANK_B_OFS = 8'h80;
	localparam logic [ADDR_W-1:0] BANK_SPAN = 8'h24;

	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SHARE_BIT = 2;
	localparam int CTRL_MERGE_BIT = 3;
	localparam int CTRL_LSB_SEL_LSB = 4;
	localparam int CTRL_LINK_BIT = 8;
	localparam int CTRL_SINGLE_IN_BIT = 9;

	// status register fields
	localparam int STATUS_MODE_LSB = 0;
	localparam int STATUS_PHASE_BIT = 2;
	localparam int STATUS_COUNT_LSB = 16;

	// reset values
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [LSB_SEL_W-1:0] LSB_SEL_RESET = 3'h0;
	localparam logic [CENTER_W-1:0] CENTER_RESET = 18'h10000;
	localparam logic [CENTER_W-1:0] SIDE_RESET = 18'h00000;

	// rounding and saturation constants
	localparam logic [FRAC_W-1:0] HALF_LSB = 16'h8000;
	localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 12'h7FF;
	localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = 12'h800;

	typedef enum logic [1:0] {EQ_BYPASS, EQ_DUAL, EQ_SINGLE, EQ_TVF} eqfir_mode_e;
	typedef logic signed [CENTER_W-1:0] eqfir_coef_t;
	typedef logic signed [ACC_W-1:0] eqfir_acc_t;

	// full-precision product, aligned to 2^-16 units
	function automatic eqfir_acc_t tap_term(
		input logic signed [SAMPLE_W-1:0] s,
		input eqfir_coef_t c,
		input logic [LSB_SEL_W-1:0] sh
	);
		eqfir_acc_t p;
		p = eqfir_acc_t'(s) * eqfir_acc_t'(c);
		return p <<< sh;
	endfunction

	// sign-extend a 12-bit side coefficient
	function automatic eqfir_coef_t side_coef(input logic [SIDE_W-1:0] raw);
		return {{(CENTER_W-SIDE_W){raw[SIDE_W-1]}}, raw};
	endfunction

	// word-aligned hit inside a coefficient bank
	function automatic logic bank_hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] base
	);
		return (a[1:0] == 2'h0) && (a >= base) && (a < base + BANK_SPAN);
	endfunction

	// tap index inside a coefficient bank
	function automatic logic [IDX_W-1:0] bank_idx(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] base
	);
		logic [ADDR_W-1:0] d;
		d = a - base;
		return d[IDX_W+1:2];
	endfunction

endpackage

// ===== eqfir_tap9.sv
`timescale 1ns/1ps
`default_nettype none

module eqfir_tap9 (
	// clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// incoming sample with its coefficient set
	input wire logic in_valid,
	input wire logic [eqfir_pkg::SAMPLE_W-1:0] in_sample,
	input wire logic [eqfir_pkg::TAPS-1:0][eqfir_pkg::CENTER_W-1:0] coef,
	input wire logic [eqfir_pkg::LSB_SEL_W-1:0] lsb_sel,
	// filtered sample
	output logic out_valid,
	output logic [eqfir_pkg::SAMPLE_W-1:0] out_sample
);

	logic signed [eqfir_pkg::SAMPLE_W-1:0] dl_q [eqfir_pkg::TAPS];
	logic [eqfir_pkg::TAPS-1:0][eqfir_pkg::CENTER_W-1:0] cf_q;
	logic [eqfir_pkg::LSB_SEL_W-1:0] sel_q;
	logic v1_q;
	eqfir_pkg::eqfir_acc_t sum_d;
	eqfir_pkg::eqfir_acc_t sum_q;
	logic v2_q;
	logic out_valid_q;
	logic [eqfir_pkg::SAMPLE_W-1:0] out_sample_q;

	// convergent rounding to whole codes, then saturation
	function automatic logic [eqfir_pkg::SAMPLE_W-1:0] round_sat(
		input eqfir_pkg::eqfir_acc_t a
	);
		eqfir_pkg::eqfir_acc_t whole;
		logic [eqfir_pkg::FRAC_W-1:0] frac;
		logic up;
		whole = a >>> eqfir_pkg::FRAC_W;
		frac = a[eqfir_pkg::FRAC_W-1:0];
		up = (frac > eqfir_pkg::HALF_LSB) ||
			((frac == eqfir_pkg::HALF_LSB) && whole[0]);
		whole = whole + eqfir_pkg::eqfir_acc_t'(up);
		if (whole > eqfir_pkg::eqfir_acc_t'(eqfir_pkg::SAMPLE_MAX))
			return eqfir_pkg::SAMPLE_MAX;
		else if (whole < eqfir_pkg::eqfir_acc_t'(eqfir_pkg::SAMPLE_MIN))
			return eqfir_pkg::SAMPLE_MIN;
		else
			return whole[eqfir_pkg::SAMPLE_W-1:0];
	endfunction

	// delay line, coefficients captured with the newest sample
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < eqfir_pkg::TAPS; i++)
				dl_q[i] <= '0;
			cf_q <= '0;
			sel_q <= eqfir_pkg::LSB_SEL_RESET;
			v1_q <= 1'b0;
		end
		else if (ce)
		begin
			v1_q <= in_valid;
			if (in_valid)
			begin
				dl_q[0] <= in_sample;
				for (int i = 1; i < eqfir_pkg::TAPS; i++)
					dl_q[i] <= dl_q[i-1];
				cf_q <= coef;
				sel_q <= lsb_sel;
			end
		end
	end

	// sum of products at full precision
	always_comb
	begin
		sum_d = '0;
		for (int i = 0; i < eqfir_pkg::TAPS; i++)
		begin
			if (i == eqfir_pkg::CENTER_TAP)
				sum_d = sum_d + eqfir_pkg::tap_term(dl_q[i], cf_q[i],
					eqfir_pkg::CENTER_SHIFT);
			else
				sum_d = sum_d + eqfir_pkg::tap_term(dl_q[i],
					eqfir_pkg::side_coef(cf_q[i][eqfir_pkg::SIDE_W-1:0]),
					eqfir_pkg::LSB_SEL_MAX - sel_q);
		end
	end

	// accumulator and rounded output stages
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sum_q <= '0;
			v2_q <= 1'b0;
			out_valid_q <= 1'b0;
			out_sample_q <= '0;
		end
		else if (ce)
		begin
			sum_q <= sum_d;
			v2_q <= v1_q;
			out_valid_q <= v2_q;
			if (v2_q)
				out_sample_q <= round_sat(sum_q);
		end
	end

	assign out_valid = out_valid_q;
	assign out_sample = out_sample_q;

	// checks on the filter pipeline
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	latency_three_a: assert property (
		(in_valid && ce) ##1 ce ##1 ce |=> out_valid_q)
		else $error("filtered sample late");

	center_weight_a: assert property (
		sum_d == eqfir_pkg::eqfir_acc_t'(dl_q[eqfir_pkg::CENTER_TAP]) *
			eqfir_pkg::eqfir_acc_t'($signed(cf_q[eqfir_pkg::CENTER_TAP]))
		|| (cf_q[3:0] != '0) || (cf_q[8:5] != '0))
		else $error("center tap weight wrong");

	exact_round_a: assert property (
		(v2_q && ce && sum_q[eqfir_pkg::FRAC_W-1:0] == '0 &&
		((&sum_q[eqfir_pkg::ACC_W-1:eqfir_pkg::FRAC_W+eqfir_pkg::SAMPLE_W-1])
		|| !(|sum_q[eqfir_pkg::ACC_W-1:eqfir_pkg::FRAC_W+eqfir_pkg::SAMPLE_W-1])))
		|=> out_sample_q == $past(sum_q[eqfir_pkg::FRAC_W+eqfir_pkg::SAMPLE_W-1:
			eqfir_pkg::FRAC_W]))
		else $error("exact sum not passed through");

	half_even_a: assert property (
		(v2_q && ce && sum_q[eqfir_pkg::FRAC_W-1:0] == eqfir_pkg::HALF_LSB &&
		!sum_q[eqfir_pkg::FRAC_W] && !(|sum_q[eqfir_pkg::ACC_W-1:
			eqfir_pkg::FRAC_W+eqfir_pkg::SAMPLE_W-1]))
		|=> out_sample_q == $past(sum_q[eqfir_pkg::FRAC_W+eqfir_pkg::SAMPLE_W-1:
			eqfir_pkg::FRAC_W]))
		else $error("half not rounded to even");

endmodule
`default_nettype wire

// ===== eqfir_top.sv
`timescale 1ns/1ps
`default_nettype none

module eqfir_top (
	// clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// register port
	input wire logic [eqfir_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [eqfir_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [eqfir_pkg::DATA_W-1:0] reg_rdata,
	// samples from the converter cores
	input wire logic a_valid,
	input wire logic [eqfir_pkg::SAMPLE_W-1:0] a_sample,
	input wire logic b_valid,
	input wire logic [eqfir_pkg::SAMPLE_W-1:0] b_sample,
	// samples toward down conversion or the serial link
	output logic oa_valid,
	output logic [eqfir_pkg::SAMPLE_W-1:0] oa_sample,
	output logic ob_valid,
	output logic [eqfir_pkg::SAMPLE_W-1:0] ob_sample
);

	logic [1:0] mode_sel_q;
	logic coeff_share_q;
	logic channel_merge_q;
	logic [eqfir_pkg::LSB_SEL_W-1:0] lsb_sel_q;
	logic link_mode_sel_q;
	logic single_input_sel_q;
	logic [eqfir_pkg::TAPS-1:0][eqfir_pkg::CENTER_W-1:0] bank_a_q;
	logic [eqfir_pkg::TAPS-1:0][eqfir_pkg::CENTER_W-1:0] bank_b_q;
	logic [eqfir_pkg::TAPS-1:0][eqfir_pkg::CENTER_W-1:0] coef_a_sel;
	logic [eqfir_pkg::DATA_W-1:0] rdata_d;
	logic [eqfir_pkg::DATA_W-1:0] rdata_q;
	logic [eqfir_pkg::LSB_SEL_W-1:0] lsb_wr;
	logic [eqfir_pkg::IDX_W-1:0] rd_idx;
	logic [eqfir_pkg::COUNT_W-1:0] filt_cnt_q;
	eqfir_pkg::eqfir_mode_e act;
	logic tv_phase_q;
	logic ctrl_wr;
	logic fa_vin;
	logic fb_vin;
	logic fa_ov;
	logic fb_ov;
	logic [eqfir_pkg::SAMPLE_W-1:0] fa_os;
	logic [eqfir_pkg::SAMPLE_W-1:0] fb_os;
	logic byp_av_q;
	logic byp_bv_q;
	logic [eqfir_pkg::SAMPLE_W-1:0] byp_a_q;
	logic [eqfir_pkg::SAMPLE_W-1:0] byp_b_q;
	logic oa_valid_q;
	logic ob_valid_q;
	logic [eqfir_pkg::SAMPLE_W-1:0] oa_sample_q;
	logic [eqfir_pkg::SAMPLE_W-1:0] ob_sample_q;

	// active filter mode from the four selects and link setting
	always_comb
	begin
		if (mode_sel_q != eqfir_pkg::MODE_ON)
			act = eqfir_pkg::EQ_BYPASS;
		else if (!coeff_share_q && !channel_merge_q && !link_mode_sel_q)
			act = eqfir_pkg::EQ_DUAL;
		else if (coeff_share_q && channel_merge_q && link_mode_sel_q)
			act = eqfir_pkg::EQ_SINGLE;
		else if (!coeff_share_q && channel_merge_q && link_mode_sel_q &&
			!single_input_sel_q)
			act = eqfir_pkg::EQ_TVF;
		else
			act = eqfir_pkg::EQ_BYPASS;
	end

	// clamp the written lsb weight select to its legal range
	assign ctrl_wr = reg_wr && (reg_addr == eqfir_pkg::CTRL_OFS);
	assign lsb_wr = (reg_wdata[eqfir_pkg::CTRL_LSB_SEL_LSB+:eqfir_pkg::LSB_SEL_W]
		> eqfir_pkg::LSB_SEL_MAX) ? eqfir_pkg::LSB_SEL_MAX :
		reg_wdata[eqfir_pkg::CTRL_LSB_SEL_LSB+:eqfir_pkg::LSB_SEL_W];

	// control register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_sel_q <= eqfir_pkg::MODE_RESET;
			coeff_share_q <= 1'b0;
			channel_merge_q <= 1'b0;
			lsb_sel_q <= eqfir_pkg::LSB_SEL_RESET;
			link_mode_sel_q <= 1'b0;
			single_input_sel_q <= 1'b0;
		end
		else if (ce && ctrl_wr)
		begin
			mode_sel_q <= reg_wdata[eqfir_pkg::CTRL_MODE_LSB+:2];
			coeff_share_q <= reg_wdata[eqfir_pkg::CTRL_SHARE_BIT];
			channel_merge_q <= reg_wdata[eqfir_pkg::CTRL_MERGE_BIT];
			lsb_sel_q <= lsb_wr;
			link_mode_sel_q <= reg_wdata[eqfir_pkg::CTRL_LINK_BIT];
			single_input_sel_q <= reg_wdata[eqfir_pkg::CTRL_SINGLE_IN_BIT];
		end
	end

	// coefficient banks, center tap resets to unity
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < eqfir_pkg::TAPS; i++)
			begin
				bank_a_q[i] <= (i == eqfir_pkg::CENTER_TAP) ?
					eqfir_pkg::CENTER_RESET : eqfir_pkg::SIDE_RESET;
				bank_b_q[i] <= (i == eqfir_pkg::CENTER_TAP) ?
					eqfir_pkg::CENTER_RESET : eqfir_pkg::SIDE_RESET;
			end
		end
		else if (ce && reg_wr)
		begin
			if (eqfir_pkg::bank_hit(reg_addr, eqfir_pkg::BANK_A_OFS))
				bank_a_q[eqfir_pkg::bank_idx(reg_addr, eqfir_pkg::BANK_A_OFS)]
					<= reg_wdata[eqfir_pkg::CENTER_W-1:0];
			if (eqfir_pkg::bank_hit(reg_addr, eqfir_pkg::BANK_B_OFS))
				bank_b_q[eqfir_pkg::bank_idx(reg_addr, eqfir_pkg::BANK_B_OFS)]
					<= reg_wdata[eqfir_pkg::CENTER_W-1:0];
		end
	end

	// read mux, unmapped addresses read zero
	always_comb
	begin
		rdata_d = '0;
		rd_idx = '0;
		if (reg_addr == eqfir_pkg::CTRL_OFS)
		begin
			rdata_d[eqfir_pkg::CTRL_MODE_LSB+:2] = mode_sel_q;
			rdata_d[eqfir_pkg::CTRL_SHARE_BIT] = coeff_share_q;
			rdata_d[eqfir_pkg::CTRL_MERGE_BIT] = channel_merge_q;
			rdata_d[eqfir_pkg::CTRL_LSB_SEL_LSB+:eqfir_pkg::LSB_SEL_W] =
				lsb_sel_q;
			rdata_d[eqfir_pkg::CTRL_LINK_BIT] = link_mode_sel_q;
			rdata_d[eqfir_pkg::CTRL_SINGLE_IN_BIT] = single_input_sel_q;
		end
		else if (reg_addr == eqfir_pkg::STATUS_OFS)
		begin
			rdata_d[eqfir_pkg::STATUS_MODE_LSB+:2] = act;
			rdata_d[eqfir_pkg::STATUS_PHASE_BIT] = tv_phase_q;
			rdata_d[eqfir_pkg::STATUS_COUNT_LSB+:eqfir_pkg::COUNT_W] =
				filt_cnt_q;
		end
		else if (eqfir_pkg::bank_hit(reg_addr, eqfir_pkg::BANK_A_OFS))
		begin
			rd_idx = eqfir_pkg::bank_idx(reg_addr, eqfir_pkg::BANK_A_OFS);
			rdata_d[eqfir_pkg::CENTER_W-1:0] = bank_a_q[rd_idx];
		end
		else if (eqfir_pkg::bank_hit(reg_addr, eqfir_pkg::BANK_B_OFS))
		begin
			rd_idx = eqfir_pkg::bank_idx(reg_addr, eqfir_pkg::BANK_B_OFS);
			rdata_d[eqfir_pkg::CENTER_W-1:0] = bank_b_q[rd_idx];
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_q <= '0;
		else if (ce)
			rdata_q <= reg_rd ? rdata_d : '0;
	end

	assign reg_rdata = rdata_q;

	// time-varying phase flips on every merged sample
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tv_phase_q <= 1'b0;
		else if (ce)
		begin
			if (act != eqfir_pkg::EQ_TVF)
				tv_phase_q <= 1'b0;
			else if (a_valid)
				tv_phase_q <= !tv_phase_q;
		end
	end

	// count of filtered samples leaving path a
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			filt_cnt_q <= '0;
		else if (ce && fa_ov)
			filt_cnt_q <= filt_cnt_q + 1'b1;
	end

	// coefficient set and stream steering per mode
	always_comb
	begin
		coef_a_sel = bank_a_q;
		if (act == eqfir_pkg::EQ_TVF && tv_phase_q)
			coef_a_sel = bank_b_q;
	end

	assign fa_vin = a_valid && (act != eqfir_pkg::EQ_BYPASS);
	assign fb_vin = b_valid && (act == eqfir_pkg::EQ_DUAL);

	// filter path a: channel a, merged stream or time-varying
	eqfir_tap9 u_fir_a (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.in_valid(fa_vin),
		.in_sample(a_sample),
		.coef(coef_a_sel),
		.lsb_sel(lsb_sel_q),
		.out_valid(fa_ov),
		.out_sample(fa_os)
	);

	// filter path b: channel b in dual mode only
	eqfir_tap9 u_fir_b (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.in_valid(fb_vin),
		.in_sample(b_sample),
		.coef(bank_b_q),
		.lsb_sel(lsb_sel_q),
		.out_valid(fb_ov),
		.out_sample(fb_os)
	);

	// bypass registers straight from the cores
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			byp_av_q <= 1'b0;
			byp_bv_q <= 1'b0;
			byp_a_q <= '0;
			byp_b_q <= '0;
		end
		else if (ce)
		begin
			byp_av_q <= a_valid;
			byp_bv_q <= b_valid;
			byp_a_q <= a_sample;
			byp_b_q <= b_sample;
		end
	end

	// output registers, filtered or bypassed per mode
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			oa_valid_q <= 1'b0;
			ob_valid_q <= 1'b0;
			oa_sample_q <= '0;
			ob_sample_q <= '0;
		end
		else if (ce)
		begin
			if (act == eqfir_pkg::EQ_BYPASS)
			begin
				oa_valid_q <= byp_av_q;
				oa_sample_q <= byp_a_q;
				ob_valid_q <= byp_bv_q;
				ob_sample_q <= byp_b_q;
			end
			else
			begin
				oa_valid_q <= fa_ov;
				oa_sample_q <= fa_os;
				ob_valid_q <= fb_ov && (act == eqfir_pkg::EQ_DUAL);
				ob_sample_q <= fb_os;
			end
		end
	end

	assign oa_valid = oa_valid_q;
	assign oa_sample = oa_sample_q;
	assign ob_valid = ob_valid_q;
	assign ob_sample = ob_sample_q;

	// checks on mode selection and steering
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	mode_bypass_a: assert property (
		(mode_sel_q != eqfir_pkg::MODE_ON) |->
		(act == eqfir_pkg::EQ_BYPASS && !fa_vin && !fb_vin))
		else $error("filter active with mode off");

	dual_select_a: assert property (
		(mode_sel_q == eqfir_pkg::MODE_ON && !coeff_share_q &&
		!channel_merge_q && !link_mode_sel_q) |-> act == eqfir_pkg::EQ_DUAL)
		else $error("dual mode not selected");

	dual_path_a: assert property (
		(act == eqfir_pkg::EQ_DUAL && b_valid && ce && !reg_wr)
		##1 ce ##1 ce ##1 ce |=> ob_valid)
		else $error("channel b not filtered");

	single_path_a: assert property (
		(act == eqfir_pkg::EQ_SINGLE) |->
		(!fb_vin && coef_a_sel == bank_a_q))
		else $error("single mode steering wrong");

	tv_toggle_a: assert property (
		(act == eqfir_pkg::EQ_TVF && a_valid && ce) |=>
		tv_phase_q != $past(tv_phase_q))
		else $error("coefficient set did not alternate");

	tv_bank_a: assert property (
		(act == eqfir_pkg::EQ_TVF) |->
		(coef_a_sel == (tv_phase_q ? bank_b_q : bank_a_q)))
		else $error("wrong coefficient set");

	lsb_range_a: assert property (
		lsb_sel_q <= eqfir_pkg::LSB_SEL_MAX)
		else $error("lsb weight out of range");

	bypass_path_a: assert property (
		(act == eqfir_pkg::EQ_BYPASS && a_valid && ce && !reg_wr) ##1 ce
		|=> (oa_valid && oa_sample == $past(a_sample, 2)))
		else $error("bypass sample lost");

	dual_run_c: cover property (act == eqfir_pkg::EQ_DUAL && fb_ov);
	single_run_c: cover property (act == eqfir_pkg::EQ_SINGLE && fa_ov);
	tv_run_c: cover property (act == eqfir_pkg::EQ_TVF && a_valid &&
		tv_phase_q ##1 a_valid);
	bank_load_c: cover property (reg_wr &&
		eqfir_pkg::bank_hit(reg_addr, eqfir_pkg::BANK_B_OFS));

endmodule
`default_nettype wire

// ===== tb_adc_equalizer_fir.sv
`timescale 1ns/1ps
`default_nettype none

module tb_adc_equalizer_fir;
	logic clk;
	logic arst_n;
	logic ce;
	logic [eqfir_pkg::ADDR_W-1:0] reg_addr;
	logic [eqfir_pkg::DATA_W-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [eqfir_pkg::DATA_W-1:0] reg_rdata;
	logic a_valid;
	logic [eqfir_pkg::SAMPLE_W-1:0] a_sample;
	logic b_valid;
	logic [eqfir_pkg::SAMPLE_W-1:0] b_sample;
	logic oa_valid;
	logic [eqfir_pkg::SAMPLE_W-1:0] oa_sample;
	logic ob_valid;
	logic [eqfir_pkg::SAMPLE_W-1:0] ob_sample;
	int miscompares;
	int n_checks;
	int cycles;
	int exp_cnt;
	int ca[9];
	int cb[9];
	logic [eqfir_pkg::DATA_W-1:0] rv;

	eqfir_top uut (.clk(clk), .arst_n(arst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.a_valid(a_valid), .a_sample(a_sample),
		.b_valid(b_valid), .b_sample(b_sample),
		.oa_valid(oa_valid), .oa_sample(oa_sample),
		.ob_valid(ob_valid), .ob_sample(ob_sample));

	eqfir_conv_model conv (.clk(clk),
		.a_valid(a_valid), .a_sample(a_sample),
		.b_valid(b_valid), .b_sample(b_sample),
		.oa_valid(oa_valid), .oa_sample(oa_sample),
		.ob_valid(ob_valid), .ob_sample(ob_sample));

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			summarize();
		end
	end

	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// register word compare
	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// output sample compare
	task automatic chk_smp(input string nm, input logic [11:0] e,
		input logic [11:0] g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// coefficient bank load, tap k at base plus 4k
	task automatic load(input int c[9], input logic [7:0] base);
		for (int k = 0; k < 9; k++)
			wr(base + 8'(4 * k), {14'h0000, 18'(c[k])});
	endtask

	// reference: 2^-16 units, convergent rounding, 12-bit saturation
	function automatic logic [11:0] fir(input int x[$], input int n,
		input int c[9], input int s);
		longint acc;
		longint q;
		longint r;
		longint t;
		acc = 0;
		for (int k = 0; k < 9; k++)
		begin
			t = (n - k >= 0) ? longint'(x[n - k]) * c[k] : 0;
			acc += (k == 4) ? t : t <<< (6 - s);
		end
		q = acc >>> 16;
		r = acc - (q <<< 16);
		if (r > 32768 || (r == 32768 && q[0]))
			q++;
		if (q > 2047)
			q = 2047;
		if (q < -2048)
			q = -2048;
		return q[11:0];
	endfunction

	// set mode, stream samples on both lanes, compare paths and status
	task automatic run(input logic [1:0] md, input logic sh, input logic mg,
		input logic [2:0] sel, input logic lk, input logic si,
		input int kind, input int n);
		int xa[$];
		int xb[$];
		int c[9];
		int se;
		logic [11:0] e;
		se = sel > 6 ? 6 : int'(sel);
		wr(eqfir_pkg::CTRL_OFS, {22'h0, si, lk, 1'b0, sel, mg, sh, md});
		repeat (4) conv.push(1'b0, 12'h000, 1'b0, 12'h000);
		conv.qa.delete();
		conv.qb.delete();
		for (int i = 0; i < n; i++)
		begin
			xa.push_back(i < 8 ? 0 : (i * 613) % 1024 - 512);
			xb.push_back(i < 8 ? 0 : (i * 271 + 99) % 1024 - 512);
			conv.push(1'b1, 12'(xa[i]), 1'b1, 12'(xb[i]));
		end
		repeat (12) conv.push(1'b0, 12'h000, 1'b0, 12'h000);
		chk_word("a count", 32'(n), 32'(conv.qa.size()));
		chk_word("b count", kind < 2 ? 32'(n) : 32'h0,
			32'(conv.qb.size()));
		for (int i = 0; i < n && i < conv.qa.size(); i++)
		begin
			c = ca;
			if (kind == 3 && i % 2 == 1)
				c = cb;
			e = kind == 0 ? 12'(xa[i]) : fir(xa, i, c, se);
			if (kind == 0 || i >= 8)
				chk_smp("oa sample", e, conv.qa[i]);
		end
		for (int i = 0; i < n && kind < 2 && i < conv.qb.size(); i++)
		begin
			e = kind == 0 ? 12'(xb[i]) : fir(xb, i, cb, se);
			if (kind == 0 || i >= 8)
				chk_smp("ob sample", e, conv.qb[i]);
		end
		if (kind != 0)
			exp_cnt += n;
		rd(eqfir_pkg::STATUS_OFS, rv);
		chk_word("status", {16'(exp_cnt), 13'h0,
			(kind == 3) && (n % 2 == 1), 2'(kind)}, rv);
		$display("test mode %0d sel %0d done", kind, sel);
	endtask

	// main sequence
	initial
	begin
		arst_n = 1'b0;
		ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		miscompares = 0;
		n_checks = 0;
		cycles = 0;
		exp_cnt = 0;
		ca = '{0, 0, 0, 0, 65536, 0, 0, 0, 0};
		cb = '{0, 0, 0, 0, 32768, 0, 0, 0, 0};
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		rd(eqfir_pkg::CTRL_OFS, rv);
		chk_word("ctrl reset", 32'h00000000, rv);
		rd(eqfir_pkg::STATUS_OFS, rv);
		chk_word("status reset", 32'h00000000, rv);
		rd(eqfir_pkg::BANK_A_OFS + 8'h10, rv);
		chk_word("center reset", 32'h00010000, rv);
		rd(eqfir_pkg::BANK_B_OFS, rv);
		chk_word("side reset", 32'h00000000, rv);
		rd(8'h30, rv);
		chk_word("unmapped read", 32'h00000000, rv);
		// a write with the clock enable low must not land
		@(posedge clk);
		ce <= 1'b0;
		wr(eqfir_pkg::CTRL_OFS, 32'h00000002);
		ce <= 1'b1;
		rd(eqfir_pkg::CTRL_OFS, rv);
		chk_word("ctrl frozen", 32'h00000000, rv);
		$display("test reset done");
		// unity center on a, half center on b: exact and tie rounding
		wr(eqfir_pkg::BANK_B_OFS + 8'h10, 32'h00008000);
		run(2'h2, 1'b0, 1'b0, 3'h4, 1'b0, 1'b0, 1, 20);
		ca = '{-300, 150, -2048, 700, 98304, 2047, -900, 40, 5};
		cb = '{12, -1000, 333, 2047, -131072, -2048, 600, -7, 250};
		load(ca, eqfir_pkg::BANK_A_OFS);
		load(cb, eqfir_pkg::BANK_B_OFS);
		run(2'h0, 1'b1, 1'b1, 3'h5, 1'b1, 1'b0, 0, 20);
		run(2'h2, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0, 0, 12);
		run(2'h2, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0, 0, 12);
		run(2'h2, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1, 40);
		run(2'h2, 1'b0, 1'b0, 3'h6, 1'b0, 1'b0, 1, 40);
		run(2'h2, 1'b0, 1'b0, 3'h7, 1'b0, 1'b0, 1, 24);
		run(2'h2, 1'b1, 1'b1, 3'h3, 1'b1, 1'b0, 2, 40);
		run(2'h2, 1'b0, 1'b1, 3'h2, 1'b1, 1'b1, 0, 12);
		run(2'h2, 1'b0, 1'b1, 3'h2, 1'b1, 1'b0, 3, 41);
		summarize();
	end
endmodule

`default_nettype wire
